// ---- inc/ata_cfg_pkg.sv ----
// Purpose: shared constants for the ata configuration command pair
// Assumes: 20 MHz clock, task-file registers byte wide
// Notes: command codes, feature codes and timing counts
package ata_cfg_pkg;
  // ****************************************************
  // command and feature codes
  // ****************************************************
  localparam logic [7:0] CMD_READ_NATIVE_MAX = 8'hf8;
  localparam logic [7:0] CMD_SET_MAX = 8'hf9;
  localparam logic [7:0] CMD_SET_MULTIPLE = 8'hc6;
  localparam logic [7:0] CMD_SLEEP_A = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B = 8'he6;
  localparam logic [7:0] CMD_SMART = 8'hb0;
  localparam logic [7:0] FEAT_SET_MAX_ADDR = 8'h00;
  localparam logic [7:0] FEAT_SET_PASSWORD = 8'h01;
  localparam logic [7:0] FEAT_LOCK = 8'h02;
  localparam logic [7:0] FEAT_UNLOCK = 8'h03;
  localparam logic [7:0] FEAT_FREEZE = 8'h04;
  localparam logic [7:0] SMART_KEY_HI = 8'hc2;
  localparam logic [7:0] SMART_KEY_LO = 8'h4f;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int LBA_MODE_BIT = 6;
  localparam int DRIVE_SEL_BIT = 4;
  localparam int KEEP_BIT = 0;
  localparam int IDENT_SMART_WORD = 82;
  localparam int IDENT_SMART_BIT = 0;
  localparam logic [7:0] ERR_ABORT = 8'h04;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 5;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int IDLE_MS = 20;
  localparam int IDLE_TICKS = IDLE_MS / TICK_MS;
  localparam logic [27:0] NATIVE_MAX_DEFAULT = 28'hfffffff;
  localparam logic [7:0] MULT_MAX_DEFAULT = 8'h10;
endpackage : ata_cfg_pkg

// ---- inc/ata_taskfile_if.sv ----
// Purpose: task-file link between host controller and device
// Assumes: same clock on both ends
// Notes: one command per strobe, answer on done pulse
`timescale 1ns/1ps
interface ata_taskfile_if;
  logic [7:0] command;
  logic [7:0] features;
  logic [7:0] sector_count;
  logic [7:0] sector_number;
  logic [7:0] cyl_low;
  logic [7:0] cyl_high;
  logic [7:0] drive_head;
  logic cmd_strobe;
  logic busy_flag;
  logic device_ready_flag;
  logic error_flag;
  logic [7:0] error_reg;
  logic [7:0] sector_count_out;
  logic [7:0] cyl_low_out;
  logic [7:0] cyl_high_out;
  logic [7:0] sector_number_out;
  logic [7:0] drive_head_out;
  logic irq;
  logic done;
  modport device (
    input command, features, sector_count, sector_number, cyl_low,
    input cyl_high, drive_head, cmd_strobe,
    output busy_flag, device_ready_flag, error_flag, error_reg,
    output sector_count_out, cyl_low_out, cyl_high_out,
    output sector_number_out, drive_head_out, irq, done
  );
  modport host (
    output command, features, sector_count, sector_number, cyl_low,
    output cyl_high, drive_head, cmd_strobe,
    input busy_flag, device_ready_flag, error_flag, error_reg,
    input sector_count_out, cyl_low_out, cyl_high_out,
    input sector_number_out, drive_head_out, irq, done
  );
endinterface : ata_taskfile_if

// ---- core/ata_tick_div.sv ----
// Purpose: one-cycle enable every tick period
// Assumes: single clock, synchronous reset
// Notes: restarts on clear
`timescale 1ns/1ps
module ata_tick_div #(
  parameter int CYCLES = ata_cfg_pkg::TICK_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_clear,
  output logic o_tick
);
  import ata_cfg_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } div_s;
  div_s st_reg;
  div_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (i_clear) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == 32'(CYCLES - 1)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_tick = st_reg.tick;
endmodule : ata_tick_div

// ---- core/ata_cfg_device.sv ----
// Purpose: device end handling five ata configuration commands
// Assumes: host keeps the task file steady while the strobe is high
// Notes: non-volatile limit is held in a register beyond hardware reset
//
// Behaviour
// - set-max command replaces highest address
// - 28-bit limit from head, cylinders and sector number
// - host sets lba bit for set-max
// - set-max needs ready and read-native before
// - sector count bit zero selects persistence
// - feature selects password, lock, unlock, freeze
// - second non-volatile set-max after reset aborts
// - host selects drive via drive-select bit
// - set-multiple raises busy, checks sector count
// - valid count stored, multiple commands enabled
// - unsupported count aborts, disables multiple
// - zero count disables multiple, no error
// - multiple disabled after power-on
// - sleep command: busy, sleep, clear, interrupt
// - any new command wakes device
// - idle timer 20 ms, 5 ms ticks
// - identify word 82 bit 0 reports smart
`timescale 1ns/1ps
module ata_cfg_device #(
  parameter int TICK_LEN = ata_cfg_pkg::TICK_CYCLES,
  parameter int IDLE_LEN = ata_cfg_pkg::IDLE_TICKS,
  parameter logic [27:0] NATIVE_MAX = ata_cfg_pkg::NATIVE_MAX_DEFAULT,
  parameter logic [7:0] MULT_MAX = ata_cfg_pkg::MULT_MAX_DEFAULT,
  parameter logic DRIVE_ID = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_POWER_ON,
  ata_taskfile_if.device tf,
  input wire logic [7:0] I_IDENT_WORD,
  output logic [15:0] O_IDENT_DATA,
  output logic [27:0] O_MAX_LBA,
  output logic O_SLEEPING,
  output logic O_MULT_EN,
  output logic [7:0] O_MULT_COUNT,
  output logic O_FROZEN
);
  import ata_cfg_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_DONE} state_e;
  typedef struct packed {
    state_e state;
    logic [7:0] cmd;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [27:0] lba;
    logic sel;
    logic prev_native;
    logic [27:0] cur_max;
    logic [27:0] nv_max;
    logic nv_done;
    logic locked;
    logic frozen;
    logic [7:0] password;
    logic mult_en;
    logic [7:0] mult_cnt;
    logic sleeping;
    logic [3:0] idle_cnt;
    logic busy;
    logic ready;
    logic err;
    logic [7:0] err_reg;
    logic irq;
    logic done;
    logic [27:0] ret_lba;
    logic [15:0] ident;
  } dev_s;
  dev_s st_reg;
  dev_s st_next;
  logic tick;
  logic strobe_me;

  function automatic logic mult_ok(input logic [7:0] n, input logic [7:0] m);
    mult_ok = (n <= m) && ((n & (n - 8'h1)) == 8'h0);
  endfunction : mult_ok

  ata_tick_div #(.CYCLES(TICK_LEN)) u_div (
    .I_CLK(I_CLK),
    .I_RST(I_RST),
    .i_clear(strobe_me),
    .o_tick(tick)
  );

  assign strobe_me = tf.cmd_strobe &&
    (tf.drive_head[DRIVE_SEL_BIT] == DRIVE_ID);

  // ****************************************************
  // command engine
  // ****************************************************
  always_comb begin
    st_next = st_reg;
    st_next.irq = 1'b0;
    st_next.done = 1'b0;
    if (!st_reg.sleeping && st_reg.state == S_IDLE && tick) begin
      if (st_reg.idle_cnt == 4'(IDLE_LEN - 1)) begin
        st_next.sleeping = 1'b1;
        st_next.idle_cnt = '0;
      end else begin
        st_next.idle_cnt = st_reg.idle_cnt + 4'h1;
      end
    end
    st_next.ident = '0;
    if (I_IDENT_WORD == 8'(IDENT_SMART_WORD)) begin
      st_next.ident[IDENT_SMART_BIT] = 1'b1;
    end
    case (st_reg.state)
      S_IDLE: begin
        if (strobe_me) begin
          st_next.sleeping = 1'b0;
          st_next.idle_cnt = '0;
          st_next.cmd = tf.command;
          st_next.feat = tf.features;
          st_next.scnt = tf.sector_count;
          st_next.lba = {tf.drive_head[3:0], tf.cyl_high, tf.cyl_low,
                         tf.sector_number};
          st_next.sel = tf.drive_head[LBA_MODE_BIT];
          st_next.busy = 1'b1;
          st_next.err = 1'b0;
          st_next.err_reg = '0;
          st_next.state = S_EXEC;
        end
      end
      S_EXEC: begin
        st_next.state = S_DONE;
        st_next.prev_native = 1'b0;
        case (st_reg.cmd)
          CMD_READ_NATIVE_MAX: begin
            st_next.ret_lba = NATIVE_MAX;
            st_next.prev_native = 1'b1;
          end
          CMD_SET_MAX: begin
            if (!st_reg.prev_native || !st_reg.sel) begin
              st_next.err = 1'b1;
            end else begin
              case (st_reg.feat)
                FEAT_SET_MAX_ADDR: begin
                  if (st_reg.frozen || st_reg.locked) begin
                    st_next.err = 1'b1;
                  end else if (st_reg.scnt[KEEP_BIT]) begin
                    if (st_reg.nv_done) begin
                      st_next.err = 1'b1;
                    end else begin
                      st_next.cur_max = st_reg.lba;
                      st_next.nv_max = st_reg.lba;
                      st_next.nv_done = 1'b1;
                    end
                  end else begin
                    st_next.cur_max = st_reg.lba;
                  end
                end
                FEAT_SET_PASSWORD: begin
                  if (st_reg.frozen) begin
                    st_next.err = 1'b1;
                  end else begin
                    st_next.password = st_reg.lba[7:0];
                  end
                end
                FEAT_LOCK: begin
                  if (st_reg.frozen) st_next.err = 1'b1;
                  else st_next.locked = 1'b1;
                end
                FEAT_UNLOCK: begin
                  if (st_reg.frozen ||
                      st_reg.lba[7:0] != st_reg.password) begin
                    st_next.err = 1'b1;
                  end else begin
                    st_next.locked = 1'b0;
                  end
                end
                FEAT_FREEZE: begin
                  if (st_reg.locked) st_next.frozen = 1'b1;
                  else st_next.err = 1'b1;
                end
                default: st_next.err = 1'b1;
              endcase
            end
          end
          CMD_SET_MULTIPLE: begin
            if (st_reg.scnt == 8'h0) begin
              st_next.mult_en = 1'b0;
            end else if (mult_ok(st_reg.scnt, MULT_MAX)) begin
              st_next.mult_en = 1'b1;
              st_next.mult_cnt = st_reg.scnt;
            end else begin
              st_next.mult_en = 1'b0;
              st_next.err = 1'b1;
            end
          end
          CMD_SLEEP_A, CMD_SLEEP_B: begin
            st_next.sleeping = 1'b1;
          end
          CMD_SMART: begin
            if (st_reg.lba[23:16] != SMART_KEY_HI ||
                st_reg.lba[15:8] != SMART_KEY_LO) begin
              st_next.err = 1'b1;
            end
          end
          default: st_next.err = 1'b1;
        endcase
        if (st_next.err) st_next.err_reg = ERR_ABORT;
      end
      S_DONE: begin
        st_next.busy = 1'b0;
        st_next.irq = 1'b1;
        st_next.done = 1'b1;
        st_next.state = S_IDLE;
      end
      default: st_next.state = S_IDLE;
    endcase
    st_next.ready = !st_next.busy;
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge I_CLK) begin
    if (I_POWER_ON) begin
      st_reg <= '0;
      st_reg.cur_max <= NATIVE_MAX;
      st_reg.nv_max <= NATIVE_MAX;
      st_reg.ready <= 1'b1;
      st_reg.state <= S_IDLE;
    end else if (I_RST) begin
      st_reg <= '0;
      st_reg.cur_max <= st_reg.nv_max;
      st_reg.frozen <= st_reg.frozen;
      st_reg.ready <= 1'b1;
      st_reg.nv_max <= st_reg.nv_max;
      st_reg.password <= st_reg.password;
      st_reg.state <= S_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tf.busy_flag = st_reg.busy;
  assign tf.device_ready_flag = st_reg.ready;
  assign tf.error_flag = st_reg.err;
  assign tf.error_reg = st_reg.err_reg;
  assign tf.sector_count_out = st_reg.scnt;
  assign tf.sector_number_out = st_reg.ret_lba[7:0];
  assign tf.cyl_low_out = st_reg.ret_lba[15:8];
  assign tf.cyl_high_out = st_reg.ret_lba[23:16];
  assign tf.drive_head_out = {4'h0, st_reg.ret_lba[27:24]};
  assign tf.irq = st_reg.irq;
  assign tf.done = st_reg.done;
  assign O_IDENT_DATA = st_reg.ident;
  assign O_MAX_LBA = st_reg.cur_max;
  assign O_SLEEPING = st_reg.sleeping;
  assign O_MULT_EN = st_reg.mult_en;
  assign O_MULT_COUNT = st_reg.mult_cnt;
  assign O_FROZEN = st_reg.frozen;
endmodule : ata_cfg_device

// ---- core/ata_cfg_host.sv ----
// Purpose: host end issuing one task-file command per request
// Assumes: device answers with a done pulse
// Notes: waits for ready before issuing
`timescale 1ns/1ps
module ata_cfg_host (
  input wire logic I_CLK,
  input wire logic I_RST,
  ata_taskfile_if.host tf,
  input wire logic I_REQ,
  input wire logic [7:0] I_CMD,
  input wire logic [7:0] I_FEAT,
  input wire logic [7:0] I_SCNT,
  input wire logic [27:0] I_LBA,
  input wire logic I_DRIVE,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_ERROR,
  output logic [27:0] O_LBA
);
  import ata_cfg_pkg::*;
  typedef enum logic [1:0] {H_IDLE, H_WAIT_RDY, H_WAIT_DONE} hstate_e;
  typedef struct packed {
    hstate_e state;
    logic [7:0] cmd;
    logic [7:0] feat;
    logic [7:0] scnt;
    logic [27:0] lba;
    logic drive;
    logic strobe;
    logic busy;
    logic done;
    logic err;
    logic [27:0] rlba;
  } host_s;
  host_s st_reg;
  host_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.strobe = 1'b0;
    st_next.done = 1'b0;
    case (st_reg.state)
      H_IDLE: begin
        if (I_REQ) begin
          st_next.cmd = I_CMD;
          st_next.feat = I_FEAT;
          st_next.scnt = I_SCNT;
          st_next.lba = I_LBA;
          st_next.drive = I_DRIVE;
          st_next.busy = 1'b1;
          st_next.state = H_WAIT_RDY;
        end
      end
      H_WAIT_RDY: begin
        if (tf.device_ready_flag && !st_reg.strobe) begin
          st_next.strobe = 1'b1;
          st_next.state = H_WAIT_DONE;
        end
      end
      H_WAIT_DONE: begin
        if (tf.done) begin
          st_next.err = tf.error_flag;
          st_next.rlba = {tf.drive_head_out[3:0], tf.cyl_high_out,
                          tf.cyl_low_out, tf.sector_number_out};
          st_next.done = 1'b1;
          st_next.busy = 1'b0;
          st_next.state = H_IDLE;
        end
      end
      default: st_next.state = H_IDLE;
    endcase
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg <= '0;
      st_reg.state <= H_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tf.command = st_reg.cmd;
  assign tf.features = st_reg.feat;
  assign tf.sector_count = st_reg.scnt;
  assign tf.sector_number = st_reg.lba[7:0];
  assign tf.cyl_low = st_reg.lba[15:8];
  assign tf.cyl_high = st_reg.lba[23:16];
  // lba mode always on, drive select from request
  assign tf.drive_head = {1'b1, 1'b1, 1'b1, st_reg.drive,
                          st_reg.lba[27:24]};
  assign tf.cmd_strobe = st_reg.strobe;
  assign O_BUSY = st_reg.busy;
  assign O_DONE = st_reg.done;
  assign O_ERROR = st_reg.err;
  assign O_LBA = st_reg.rlba;
endmodule : ata_cfg_host

// ---- testbench/ata_cfg_assertions.sv ----
// Purpose: protocol checks on the task-file link
// Assumes: one clock, synchronous active-high reset
// Notes: instantiated beside the interface, no bind
`timescale 1ns/1ps
module ata_cfg_assertions
  import ata_cfg_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX = 28'hfffffff,
  parameter logic DRIVE_ID = 1'b0
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic [7:0] command,
  input wire logic [7:0] sector_count,
  input wire logic [7:0] cyl_low,
  input wire logic [7:0] cyl_high,
  input wire logic [7:0] drive_head,
  input wire logic cmd_strobe,
  input wire logic busy_flag,
  input wire logic device_ready_flag,
  input wire logic error_flag,
  input wire logic [7:0] error_reg,
  input wire logic [7:0] sector_number_out,
  input wire logic [7:0] cyl_low_out,
  input wire logic [7:0] cyl_high_out,
  input wire logic [7:0] drive_head_out,
  input wire logic irq,
  input wire logic done
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic taken;
  logic [7:0] last_cmd_reg;
  logic chain_reg;
  assign taken = cmd_strobe && !busy_flag
    && (drive_head[DRIVE_SEL_BIT] == DRIVE_ID);
  // chain: last finished command was a good read-native
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      last_cmd_reg <= 8'h00;
      chain_reg <= 1'b0;
    end else begin
      if (taken) last_cmd_reg <= command;
      if (done)
        chain_reg <= (last_cmd_reg == CMD_READ_NATIVE_MAX) && !error_flag;
    end
  end
  AST_BUSY_TWO: assert property (taken |=> busy_flag [*2] ##1 !busy_flag)
    else $error("busy not two cycles after a taken command");
  AST_DONE_AT_3: assert property (taken |-> ##3 done)
    else $error("done missing three cycles after command");
  AST_IRQ_DONE: assert property (done |-> irq)
    else $error("completion without interrupt");
  AST_DONE_ONE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_READY_NOT_BUSY: assert property (device_ready_flag != busy_flag)
    else $error("ready flag not inverse of busy");
  AST_SETMAX_CHAIN: assert property (taken && command == CMD_SET_MAX
    && !chain_reg |-> ##3 error_flag && error_reg == ERR_ABORT)
    else $error("set-max without read-native not aborted");
  AST_SMART_KEY: assert property (taken && command == CMD_SMART
    && (cyl_high != SMART_KEY_HI || cyl_low != SMART_KEY_LO)
    |-> ##3 error_flag)
    else $error("monitoring command with bad key not aborted");
  AST_MULT_ZERO: assert property (taken && command == CMD_SET_MULTIPLE
    && sector_count == 8'h00 |-> ##3 !error_flag)
    else $error("zero block count reported an error");
  AST_NATIVE_OUT: assert property (taken
    && command == CMD_READ_NATIVE_MAX |-> ##3 {drive_head_out[3:0],
    cyl_high_out, cyl_low_out, sector_number_out} == NATIVE_MAX)
    else $error("read-native returned wrong limit");
  cover property (taken && command == CMD_SET_MAX && chain_reg);
  cover property (taken && command == CMD_SLEEP_B);
  cover property (taken && command == CMD_SET_MULTIPLE ##3 error_flag);
endmodule : ata_cfg_assertions

// ---- testbench/ata_config_command_handler_tb.sv ----
// Purpose: host and device ends joined, driven from the host user side
// Assumes: shortened tick divider, one drive on the link
// Notes: expected results queued by driver, compared by monitor
`timescale 1ns/1ps
module ata_config_command_handler_tb;
  import ata_cfg_pkg::*;
  localparam logic [27:0] NMAX = 28'h9a5c3e1;
  typedef struct packed {logic err; logic use_lba;} exp_s;
  exp_s exp_q[$];
  logic clk, rst, power_on, req, drive;
  logic [7:0] ident_word, cmd, feat, scnt, mult_count;
  logic [15:0] ident_data;
  logic [27:0] lba, max_lba, h_lba;
  logic sleeping, mult_en, frozen, h_busy, h_done, h_error;
  int error_cnt = 0;
  int checks_done = 0;
  ata_taskfile_if ata_taskfile_if_i ();
  ata_cfg_device #(.TICK_LEN(10), .IDLE_LEN(4), .NATIVE_MAX(NMAX))
  ata_cfg_device_i (.I_CLK(clk), .I_RST(rst), .I_POWER_ON(power_on),
    .tf(ata_taskfile_if_i), .I_IDENT_WORD(ident_word),
    .O_IDENT_DATA(ident_data), .O_MAX_LBA(max_lba), .O_SLEEPING(sleeping),
    .O_MULT_EN(mult_en), .O_MULT_COUNT(mult_count), .O_FROZEN(frozen));
  ata_cfg_host ata_cfg_host_i (.I_CLK(clk), .I_RST(rst),
    .tf(ata_taskfile_if_i), .I_REQ(req), .I_CMD(cmd), .I_FEAT(feat),
    .I_SCNT(scnt), .I_LBA(lba), .I_DRIVE(drive), .O_BUSY(h_busy),
    .O_DONE(h_done), .O_ERROR(h_error), .O_LBA(h_lba));
  ata_cfg_assertions #(.NATIVE_MAX(NMAX), .DRIVE_ID(1'b0))
  ata_cfg_assertions_i (.I_CLK(clk), .I_RST(rst),
    .command(ata_taskfile_if_i.command),
    .sector_count(ata_taskfile_if_i.sector_count),
    .cyl_low(ata_taskfile_if_i.cyl_low),
    .cyl_high(ata_taskfile_if_i.cyl_high),
    .drive_head(ata_taskfile_if_i.drive_head),
    .cmd_strobe(ata_taskfile_if_i.cmd_strobe),
    .busy_flag(ata_taskfile_if_i.busy_flag),
    .device_ready_flag(ata_taskfile_if_i.device_ready_flag),
    .error_flag(ata_taskfile_if_i.error_flag),
    .error_reg(ata_taskfile_if_i.error_reg),
    .sector_number_out(ata_taskfile_if_i.sector_number_out),
    .cyl_low_out(ata_taskfile_if_i.cyl_low_out),
    .cyl_high_out(ata_taskfile_if_i.cyl_high_out),
    .drive_head_out(ata_taskfile_if_i.drive_head_out),
    .irq(ata_taskfile_if_i.irq), .done(ata_taskfile_if_i.done));
  // ****************************************************
  // clock, helpers
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic do_reset(input logic po, input int n);
    rst = 1'b1;
    power_on = po;
    repeat (n) @(posedge clk);
    #1 rst = 1'b0;
    power_on = 1'b0;
    @(posedge clk);
    #1;
  endtask : do_reset
  // one request, wait bounded for completion
  task automatic issue(input logic [7:0] c, f, s, input logic [27:0] a,
                       input logic e, u);
    int n;
    exp_q.push_back('{e, u});
    cmd = c;
    feat = f;
    scnt = s;
    lba = a;
    req = 1'b1;
    @(posedge clk);
    #1 req = 1'b0;
    chk(h_busy, 1'b1);
    n = 0;
    while (h_done !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 64) chk(32'h0, 32'h1);
    @(posedge clk);
    #1;
  endtask : issue
  task automatic setmax(input logic [7:0] f, s, input logic [27:0] a,
                        input logic e);
    issue(CMD_READ_NATIVE_MAX, 8'h00, 8'h00, 28'h0, 1'b0, 1'b1);
    issue(CMD_SET_MAX, f, s, a, e, 1'b0);
  endtask : setmax
  always @(posedge clk) begin : mon
    exp_s x;
    if (h_done === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h0, 32'h1);
      else begin
        x = exp_q.pop_front();
        chk(h_error, x.err);
        if (x.use_lba) chk(h_lba, NMAX);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  // ****************************************************
  // tests
  // ****************************************************
  initial begin : main
    logic [27:0] r1, r2;
    logic [7:0] c;
    logic ok;
    {rst, power_on, req, drive} = 4'b1100;
    {cmd, feat, scnt, ident_word} = 32'h0;
    lba = 28'h0;
    r1 = 28'($urandom(32'hfa83));
    @(posedge clk);
    #1 do_reset(1'b1, 16);
    chk(mult_en, 1'b0);
    chk(max_lba, NMAX);
    ident_word = 8'd82;
    repeat (2) @(posedge clk);
    #1 chk(ident_data, 32'h1 << IDENT_SMART_BIT);
    ident_word = 8'($urandom_range(0, 81));
    repeat (2) @(posedge clk);
    #1 chk(ident_data, 32'h0);
    $display("test reset done");
    issue(CMD_SET_MAX, FEAT_SET_MAX_ADDR, 8'h00, NMAX, 1'b1, 1'b0);
    r1 = 28'($urandom_range(0, int'(NMAX)));
    r2 = 28'($urandom_range(0, int'(NMAX)));
    setmax(FEAT_SET_MAX_ADDR, 8'h00, r1, 1'b0);
    chk(max_lba, r1);
    do_reset(1'b0, 2);
    chk(max_lba, NMAX);
    setmax(FEAT_SET_MAX_ADDR, 8'h01, r2, 1'b0);
    do_reset(1'b0, 2);
    chk(max_lba, r2);
    setmax(FEAT_SET_MAX_ADDR, 8'h01, r1, 1'b0);
    setmax(FEAT_SET_MAX_ADDR, 8'h01, r2, 1'b1);
    chk(max_lba, r1);
    $display("test limit done");
    c = 8'($urandom());
    setmax(FEAT_SET_PASSWORD, 8'h00, {20'h0, c}, 1'b0);
    setmax(FEAT_LOCK, 8'h00, 28'h0, 1'b0);
    setmax(FEAT_UNLOCK, 8'h00, {20'h0, ~c}, 1'b1);
    setmax(FEAT_UNLOCK, 8'h00, {20'h0, c}, 1'b0);
    setmax(FEAT_LOCK, 8'h00, 28'h0, 1'b0);
    setmax(FEAT_FREEZE, 8'h00, 28'h0, 1'b0);
    chk(frozen, 1'b1);
    setmax(FEAT_UNLOCK, 8'h00, {20'h0, c}, 1'b1);
    setmax(FEAT_SET_MAX_ADDR, 8'h00, r2, 1'b1);
    do_reset(1'b0, 2);
    chk(frozen, 1'b1);
    setmax(FEAT_SET_MAX_ADDR, 8'h00, r1, 1'b1);
    do_reset(1'b1, 2);
    chk(frozen, 1'b0);
    $display("test lock done");
    issue(CMD_SET_MULTIPLE, 8'h00, 8'h00, 28'h0, 1'b0, 1'b0);
    chk(mult_en, 1'b0);
    for (int i = 0; i < 16; i++) begin
      c = (i < 6) ? (8'h01 << i) : 8'($urandom());
      ok = (c != 8'h00) && ((c & (c - 8'h01)) == 8'h00)
        && (c <= MULT_MAX_DEFAULT);
      issue(CMD_SET_MULTIPLE, 8'h00, c, 28'h0, !ok && c != 8'h00,
        1'b0);
      chk(mult_en, ok);
      if (ok) chk(mult_count, c);
    end
    $display("test multiple done");
    for (int i = 0; i < 2; i++) begin
      issue(i ? CMD_SLEEP_B : CMD_SLEEP_A, 8'h00, 8'h00, 28'h0, 1'b0,
        1'b0);
      chk(sleeping, 1'b1);
      issue(CMD_SET_MULTIPLE, 8'h00, 8'h00, 28'h0, 1'b0, 1'b0);
      chk(sleeping, 1'b0);
    end
    repeat (28) @(posedge clk);
    #1 chk(sleeping, 1'b0);
    repeat (30) @(posedge clk);
    #1 chk(sleeping, 1'b1);
    $display("test sleep done");
    issue(CMD_SMART, 8'hd0, 8'h00, {4'h0, SMART_KEY_HI, SMART_KEY_LO,
      8'h00}, 1'b0, 1'b0);
    issue(CMD_SMART, 8'hd0, 8'h00, {4'h0, SMART_KEY_LO, SMART_KEY_HI,
      8'h00}, 1'b1, 1'b0);
    $display("test monitoring done");
    end_sim();
  end
endmodule : ata_config_command_handler_tb
